// file: design/rpf_pkg.sv
// Purpose: constants, register map and mode helpers for the radio packet framer
// Assumes: 10 MHz clock, 16-bit register port, byte-wide symbol link to the modem
//
// Contract
// - packets open with a two-symbol start marker
// - marker forced on, optional or absent per mode
// - framing off: two correlations declare packet start
// - marker code length set apart from body
// - both ends use equal marker code length
// - length field needs marker; forced in two modes
// - length is eight bits right after marker
// - end after length bytes plus two crc
// - end after programmable non-correlation run
// - append 16-bit usb crc from a seed
// - transmit crc seed is loaded or zero
// - receive crc accepted against seed or zero
// - 98 channels, number held in configuration
// - spreading in spread modes, framing in fsk
// - auto acknowledge after each valid packet
// - receive any rate except single rate unchanged
// - payloads to 40 bytes through 16-byte buffers
// - acknowledge traffic leaves packet buffers untouched
package rpf_pkg;
	localparam int          CLK_NS         = 100;
	localparam int          FSK_BYTE_NS    = 8000;
	localparam int          EBS_BYTE_NS    = 32000;
	localparam int          DDR_BYTE_NS    = 128000;
	localparam int          SDR_BYTE_NS    = 512000;
	localparam int          FSK_BYTE_CYC   = FSK_BYTE_NS / CLK_NS;
	localparam int          EBS_BYTE_CYC   = EBS_BYTE_NS / CLK_NS;
	localparam int          DDR_BYTE_CYC   = DDR_BYTE_NS / CLK_NS;
	localparam int          SDR_BYTE_CYC   = SDR_BYTE_NS / CLK_NS;
	localparam int          MARKER_SYMS    = 2;
	localparam int          MAX_PAYLOAD    = 40;
	localparam int          BUF_DEPTH      = 16;
	localparam int          NUM_CHANNELS   = 98;
	localparam logic [15:0] CRC_POLY_REFL  = 16'hA001;
	// register byte offsets
	localparam logic [7:0]  REG_CTRL       = 8'h00;
	localparam logic [7:0]  REG_SEED       = 8'h04;
	localparam logic [7:0]  REG_CODE       = 8'h08;
	localparam logic [7:0]  REG_NCORR      = 8'h0C;
	localparam logic [7:0]  REG_CHAN       = 8'h10;
	localparam logic [7:0]  REG_TXLEN      = 8'h14;
	localparam logic [7:0]  REG_CMD        = 8'h18;
	localparam logic [7:0]  REG_STAT       = 8'h1C;
	localparam logic [7:0]  REG_TXDATA     = 8'h20;
	localparam logic [7:0]  REG_RXDATA     = 8'h24;
	// register field positions
	localparam int          CTRL_FRAME     = 0;
	localparam int          CTRL_LEN       = 1;
	localparam int          CTRL_CRC       = 2;
	localparam int          CTRL_TXZERO    = 3;
	localparam int          CTRL_AUTOACK   = 4;
	localparam int          CTRL_NCORR     = 5;
	localparam int          CTRL_MODE_LO   = 8;
	localparam int          CODE_MARK64    = 0;
	localparam int          CODE_BODY64    = 1;
	localparam int          STAT_TXBUSY    = 0;
	localparam int          STAT_RXDONE    = 1;
	localparam int          STAT_CRCERR    = 2;
	localparam int          STAT_ACKSENT   = 3;
	localparam int          STAT_RXOVF     = 4;
	localparam int          STAT_RXBUSY    = 5;
	localparam int          CMD_TXGO       = 0;
	// reset values
	localparam logic [9:0]  CTRL_RESET     = 10'h007;
	localparam logic [15:0] SEED_RESET     = 16'h0000;
	localparam logic [1:0]  CODE_RESET     = 2'h0;
	localparam logic [7:0]  NCORR_RESET    = 8'h04;
	localparam logic [6:0]  CHAN_RESET     = 7'h00;
	// mode field encoding
	localparam logic [1:0]  MODE_FSK       = 2'h0;
	localparam logic [1:0]  MODE_EBS       = 2'h1;
	localparam logic [1:0]  MODE_DDR       = 2'h2;
	localparam logic [1:0]  MODE_SDR       = 2'h3;

	function automatic logic rpf_marker_on(input logic [1:0] m, input logic fr);
		rpf_marker_on = (m == MODE_FSK) || (m == MODE_EBS) || ((m == MODE_DDR) && fr);
	endfunction : rpf_marker_on

	function automatic logic rpf_len_on(input logic [1:0] m, input logic fr, input logic le);
		rpf_len_on = rpf_marker_on(m, fr) && ((m == MODE_FSK) || (m == MODE_EBS) || le);
	endfunction : rpf_len_on
endpackage : rpf_pkg

// file: design/rpf_crc16.sv
// Purpose: byte-wide crc16 engine, usb polynomial, bit-reflected, programmable seed
// Assumes: load and step never in the same cycle
// Notes:   no final inversion; the register value is sent as is
`timescale 1ns/1ps
module rpf_crc16
	import rpf_pkg::*;
(
	input  wire logic        clk_i,   // clock
	input  wire logic        rst_ni,  // synchronised reset
	input  wire logic        load_i,  // load seed
	input  wire logic [15:0] seed_i,  // start value
	input  wire logic        step_i,  // fold in one byte
	input  wire logic [7:0]  byte_i,  // data byte
	output logic      [15:0] crc_o    // running value
);
	function automatic logic [15:0] rpf_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY_REFL) : (r >> 1);
		end
		rpf_step = r;
	endfunction : rpf_step

	always_ff @(posedge clk_i or negedge rst_ni) begin
		if (!rst_ni) begin
			crc_o <= 16'h0000;
		end else if (load_i) begin
			crc_o <= seed_i;
		end else if (step_i) begin
			crc_o <= rpf_step(crc_o, byte_i);
		end
	end
endmodule : rpf_crc16

// file: design/rpf_top.sv
// Purpose: packet framer: marker, length, crc, end inference, auto acknowledge
// Assumes: modem link logic runs on clk_i; one byte or marker symbol per strobe
// Notes:   registers on a plain 16-bit port, read data one cycle after the strobe
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
module rpf_top
	import rpf_pkg::*;
#(
	parameter int SDR_CYC = SDR_BYTE_CYC  // single rate byte period in cycles
) (
	input  wire logic        clk_i,            // 10 MHz clock
	input  wire logic        nrst_i,           // async reset, active low
	input  wire logic [7:0]  addr_i,           // register byte address
	input  wire logic [15:0] wdata_i,          // write data
	input  wire logic        wr_i,             // write strobe
	input  wire logic        rd_i,             // read strobe
	output logic      [15:0] rdata_o,          // read data, cycle after rd_i
	output logic             air_tx_on_o,      // frame in progress
	output logic             air_tx_stb_o,     // one symbol out
	output logic             air_tx_marker_o,  // symbol is start marker
	output logic      [7:0]  air_tx_byte_o,    // symbol byte
	input  wire logic        air_rx_stb_i,     // one symbol period received
	input  wire logic        air_rx_corr_i,    // symbol correlated
	input  wire logic        air_rx_marker_i,  // marker code correlated
	input  wire logic [7:0]  air_rx_byte_i,    // despread byte
	input  wire logic [1:0]  air_rx_rate_i,    // detected rate of frame
	output logic      [6:0]  channel_o,        // channel number
	output logic      [1:0]  mode_o,           // link mode
	output logic             spread_en_o,      // modem spreads and despreads
	output logic             marker_64_o,      // marker code 64 chips
	output logic             body_64_o         // body code 64 chips
);
	typedef enum logic [2:0] {T_IDLE, T_MARK, T_LEN, T_BODY, T_CRCL, T_CRCH} rpf_tx_e;
	typedef enum logic [1:0] {R_HUNT, R_LEN, R_BODY, R_CHECK} rpf_rx_e;

	logic        rs1_ff, rst_n;
	logic [9:0]  ctrl_ff;
	logic [15:0] seed_ff;
	logic [1:0]  code_ff;
	logic [7:0]  ncorr_ff;
	logic [6:0]  chan_ff;
	logic [5:0]  txlen_ff;
	logic        rxdone_ff, crcerr_ff, acksent_ff, rxovf_ff;
	logic        ack_req_ff;
	rpf_tx_e     tx_st_ff;
	rpf_rx_e     rx_st_ff;
	logic [7:0]  txb [BUF_DEPTH];
	logic [7:0]  rxb [BUF_DEPTH];
	logic [4:0]  tx_wp_ff, tx_rp_ff, rx_wp_ff, rx_rp_ff;
	logic [12:0] tick_cnt_ff;
	logic        tick;
	logic        tx_ack_ff, tx_crc_ff, tx_mark_ff;
	logic        tx_mcnt_ff;
	logic [5:0]  tx_cnt_ff;
	logic [1:0]  rx_hunt_ff;
	logic [1:0]  rx_mode_ff;
	logic [7:0]  rx_need_ff, rx_cnt_ff, rx_nc_ff;
	logic        rx_crc_ff, rx_len_ff;
	logic [7:0]  p0_ff, p1_ff;
	logic [1:0]  pcnt_ff;
	logic [15:0] tx_crc, rx_crc_s, rx_crc_z;

	wire logic [1:0] mode   = ctrl_ff[CTRL_MODE_LO +: 2];
	wire logic       fr_en  = ctrl_ff[CTRL_FRAME];
	wire logic       crc_en = ctrl_ff[CTRL_CRC];
	wire logic       mark_on = rpf_marker_on(mode, fr_en);
	wire logic       len_on  = rpf_len_on(mode, fr_en, ctrl_ff[CTRL_LEN]);
	wire logic       ncorr_on = ctrl_ff[CTRL_NCORR] && (mode != MODE_FSK);
	wire logic       wr_sel_ctrl = wr_i && (addr_i == REG_CTRL);
	wire logic       tx_go = wr_i && (addr_i == REG_CMD) && wdata_i[CMD_TXGO];
	wire logic       tx_empty = (tx_wp_ff == tx_rp_ff);
	wire logic       tx_full  = (tx_wp_ff == {~tx_rp_ff[4], tx_rp_ff[3:0]});
	wire logic       rx_empty = (rx_wp_ff == rx_rp_ff);
	wire logic       rx_full  = (rx_wp_ff == {~rx_rp_ff[4], rx_rp_ff[3:0]});
	wire logic       rx_sym   = air_rx_stb_i && air_rx_corr_i;
	wire logic       rx_body  = (rx_st_ff == R_BODY) && rx_sym;
	wire logic       rx_emit  = rx_body && (!rx_crc_ff || (pcnt_ff == 2'd2));
	wire logic [7:0] rx_emit_b = rx_crc_ff ? p1_ff : air_rx_byte_i;
	wire logic       rx_ok = !rx_crc_ff || ((pcnt_ff == 2'd2) &&
	                         (({p0_ff, p1_ff} == rx_crc_s) || ({p0_ff, p1_ff} == rx_crc_z)));
	wire logic       tx_start = (tx_st_ff == T_IDLE) && (ack_req_ff || tx_go);
	wire logic       tx_pop = tick && (tx_st_ff == T_BODY) && !tx_ack_ff && !tx_empty && (tx_cnt_ff != txlen_ff);

	// reset release through two flip-flops
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rs1_ff <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rs1_ff <= 1'b1;
			rst_n  <= rs1_ff;
		end
	end

	// configuration, held until rewritten
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff  <= CTRL_RESET;
			seed_ff  <= SEED_RESET;
			code_ff  <= CODE_RESET;
			ncorr_ff <= NCORR_RESET;
			chan_ff  <= CHAN_RESET;
			txlen_ff <= 6'd0;
		end else if (wr_i) begin
			if (wr_sel_ctrl)
				ctrl_ff <= wdata_i[9:0];
			if (addr_i == REG_SEED)
				seed_ff <= wdata_i;
			if (addr_i == REG_CODE)
				code_ff <= wdata_i[1:0];
			if (addr_i == REG_NCORR)
				ncorr_ff <= (wdata_i[7:0] == 8'h00) ? 8'h01 : wdata_i[7:0];
			if (addr_i == REG_CHAN)
				chan_ff <= (wdata_i[6:0] > 7'(NUM_CHANNELS - 1)) ? 7'(NUM_CHANNELS - 1) : wdata_i[6:0];
			if (addr_i == REG_TXLEN)
				txlen_ff <= (wdata_i[5:0] > 6'(MAX_PAYLOAD)) ? 6'(MAX_PAYLOAD) : wdata_i[5:0];
		end
	end

	assign channel_o   = chan_ff;
	assign mode_o      = mode;
	assign spread_en_o = (mode != MODE_FSK);
	assign marker_64_o = code_ff[CODE_MARK64];
	assign body_64_o   = code_ff[CODE_BODY64];

	// sticky status, set wins over write-one clear
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rxdone_ff  <= 1'b0;
			crcerr_ff  <= 1'b0;
			acksent_ff <= 1'b0;
			rxovf_ff   <= 1'b0;
		end else begin
			rxdone_ff  <= (rx_st_ff == R_CHECK) ||
			              (rxdone_ff && !(wr_i && addr_i == REG_STAT && wdata_i[STAT_RXDONE]));
			crcerr_ff  <= ((rx_st_ff == R_CHECK) && !rx_ok) ||
			              (crcerr_ff && !(wr_i && addr_i == REG_STAT && wdata_i[STAT_CRCERR]));
			acksent_ff <= ((tx_st_ff != T_IDLE) && tx_ack_ff && tick && (tx_st_ff == T_CRCH)) ||
			              (acksent_ff && !(wr_i && addr_i == REG_STAT && wdata_i[STAT_ACKSENT]));
			rxovf_ff   <= (rx_emit && rx_full) ||
			              (rxovf_ff && !(wr_i && addr_i == REG_STAT && wdata_i[STAT_RXOVF]));
		end
	end

	// buffers: host fills tx and drains rx while the frame runs
	always_ff @(posedge clk_i) begin
		if (wr_i && addr_i == REG_TXDATA && !tx_full)
			txb[tx_wp_ff[3:0]] <= wdata_i[7:0];
		if (rx_emit && !rx_full)
			rxb[rx_wp_ff[3:0]] <= rx_emit_b;
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			tx_wp_ff <= 5'd0;
			tx_rp_ff <= 5'd0;
			rx_wp_ff <= 5'd0;
			rx_rp_ff <= 5'd0;
		end else begin
			if (wr_i && addr_i == REG_TXDATA && !tx_full)
				tx_wp_ff <= tx_wp_ff + 5'd1;
			if (tx_pop)
				tx_rp_ff <= tx_rp_ff + 5'd1;
			if (rx_emit && !rx_full)
				rx_wp_ff <= rx_wp_ff + 5'd1;
			if (rd_i && addr_i == REG_RXDATA && !rx_empty)
				rx_rp_ff <= rx_rp_ff + 5'd1;
		end
	end

	// register read, one cycle later; rx data pops on read
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rdata_o <= 16'h0000;
		end else if (rd_i) begin
			case (addr_i)
				REG_CTRL:   rdata_o <= {6'h00, ctrl_ff};
				REG_SEED:   rdata_o <= seed_ff;
				REG_CODE:   rdata_o <= {14'h0000, code_ff};
				REG_NCORR:  rdata_o <= {8'h00, ncorr_ff};
				REG_CHAN:   rdata_o <= {9'h000, chan_ff};
				REG_TXLEN:  rdata_o <= {10'h000, txlen_ff};
				REG_STAT:   rdata_o <= {10'h000, rx_st_ff != R_HUNT, rxovf_ff, acksent_ff,
				                        crcerr_ff, rxdone_ff, tx_st_ff != T_IDLE};
				REG_RXDATA: rdata_o <= rx_empty ? 16'h0000 : {8'h00, rxb[rx_rp_ff[3:0]]};
				default:    rdata_o <= 16'h0000;
			endcase
		end
	end

	// symbol period divider, rate set by mode
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_ff <= 13'd0;
		end else if (tx_st_ff == T_IDLE || tick) begin
			case (mode)
				MODE_FSK: tick_cnt_ff <= 13'(FSK_BYTE_CYC - 1);
				MODE_EBS: tick_cnt_ff <= 13'(EBS_BYTE_CYC - 1);
				MODE_DDR: tick_cnt_ff <= 13'(DDR_BYTE_CYC - 1);
				default:  tick_cnt_ff <= 13'(SDR_CYC - 1);
			endcase
		end else begin
			tick_cnt_ff <= tick_cnt_ff - 13'd1;
		end
	end
	assign tick = (tx_st_ff != T_IDLE) && (tick_cnt_ff == 13'd0);

	// transmit sequencer
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			tx_st_ff   <= T_IDLE;
			tx_ack_ff  <= 1'b0;
			tx_crc_ff  <= 1'b0;
			tx_mark_ff <= 1'b0;
			tx_mcnt_ff <= 1'b0;
			tx_cnt_ff  <= 6'd0;
		end else begin
			case (tx_st_ff)
				T_IDLE: if (tx_start) begin
					tx_ack_ff  <= ack_req_ff;
					tx_crc_ff  <= crc_en;
					tx_mark_ff <= mark_on;
					tx_mcnt_ff <= 1'b0;
					tx_cnt_ff  <= 6'd0;
					tx_st_ff   <= mark_on ? T_MARK : T_BODY;
				end
				T_MARK: if (tick) begin
					tx_mcnt_ff <= 1'b1;
					if (tx_mcnt_ff == 1'(MARKER_SYMS - 1))
						tx_st_ff <= len_on ? T_LEN : T_BODY;
				end
				T_LEN: if (tick)
					tx_st_ff <= T_BODY;
				T_BODY: if (tick) begin
					if (tx_ack_ff || tx_cnt_ff == txlen_ff)
						tx_st_ff <= tx_crc_ff ? T_CRCL : T_IDLE;
					else if (!tx_empty)
						tx_cnt_ff <= tx_cnt_ff + 6'd1;
				end
				T_CRCL: if (tick)
					tx_st_ff <= T_CRCH;
				T_CRCH: if (tick)
					tx_st_ff <= T_IDLE;
				default: tx_st_ff <= T_IDLE;
			endcase
		end
	end

	// symbol output; body waits while the buffer is empty
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			air_tx_stb_o    <= 1'b0;
			air_tx_marker_o <= 1'b0;
			air_tx_byte_o   <= 8'h00;
		end else begin
			air_tx_stb_o    <= 1'b0;
			air_tx_marker_o <= 1'b0;
			if (tick) begin
				case (tx_st_ff)
					T_MARK: begin
						air_tx_stb_o    <= 1'b1;
						air_tx_marker_o <= 1'b1;
					end
					T_LEN: begin
						air_tx_stb_o  <= 1'b1;
						air_tx_byte_o <= tx_ack_ff ? 8'h00 : {2'b00, txlen_ff};
					end
					T_BODY: if (!tx_ack_ff && tx_cnt_ff != txlen_ff && !tx_empty) begin
						air_tx_stb_o  <= 1'b1;
						air_tx_byte_o <= txb[tx_rp_ff[3:0]];
					end
					T_CRCL: begin
						air_tx_stb_o  <= 1'b1;
						air_tx_byte_o <= tx_crc[7:0];
					end
					T_CRCH: begin
						air_tx_stb_o  <= 1'b1;
						air_tx_byte_o <= tx_crc[15:8];
					end
					default: air_tx_stb_o <= 1'b0;
				endcase
			end
		end
	end
	assign air_tx_on_o = (tx_st_ff != T_IDLE);

	rpf_crc16 u_tx_crc (
		.clk_i  (clk_i),
		.rst_ni (rst_n),
		.load_i (tx_start),
		.seed_i (ctrl_ff[CTRL_TXZERO] ? 16'h0000 : seed_ff),
		.step_i (tx_pop),
		.byte_i (txb[tx_rp_ff[3:0]]),
		.crc_o  (tx_crc)
	);

	// receive sequencer
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rx_st_ff   <= R_HUNT;
			rx_hunt_ff <= 2'd0;
			rx_mode_ff <= MODE_FSK;
			rx_need_ff <= 8'd0;
			rx_cnt_ff  <= 8'd0;
			rx_nc_ff   <= 8'd0;
			rx_crc_ff  <= 1'b0;
			rx_len_ff  <= 1'b0;
			ack_req_ff <= 1'b0;
		end else begin
			if (tx_start)
				ack_req_ff <= 1'b0;
			case (rx_st_ff)
				R_HUNT: if (air_rx_stb_i) begin
					// marker symbols when framed outside single rate, any correlation otherwise
					if ((fr_en && mode != MODE_SDR) ? air_rx_marker_i : air_rx_corr_i) begin
						rx_hunt_ff <= rx_hunt_ff + 2'd1;
						if (rx_hunt_ff == 2'(MARKER_SYMS - 1)) begin
							rx_hunt_ff <= 2'd0;
							rx_cnt_ff  <= 8'd0;
							rx_nc_ff   <= 8'd0;
							rx_crc_ff  <= crc_en;
							rx_mode_ff <= (fr_en && mode != MODE_SDR) ? air_rx_rate_i : mode;
							rx_len_ff  <= (fr_en && mode != MODE_SDR) ?
							              rpf_len_on(air_rx_rate_i, 1'b1, ctrl_ff[CTRL_LEN]) : len_on;
							rx_need_ff <= 8'(MAX_PAYLOAD + 2);
							rx_st_ff   <= ((fr_en && mode != MODE_SDR) ?
							              rpf_len_on(air_rx_rate_i, 1'b1, ctrl_ff[CTRL_LEN]) : len_on) ?
							              R_LEN : R_BODY;
						end
					end else begin
						rx_hunt_ff <= 2'd0;
					end
				end
				R_LEN: if (rx_sym) begin
					if (air_rx_byte_i > 8'(MAX_PAYLOAD)) begin
						rx_st_ff <= R_HUNT;
					end else begin
						rx_need_ff <= air_rx_byte_i + (rx_crc_ff ? 8'd2 : 8'd0);
						rx_st_ff   <= (air_rx_byte_i == 8'd0 && !rx_crc_ff) ? R_CHECK : R_BODY;
					end
				end
				R_BODY: if (air_rx_stb_i) begin
					if (air_rx_corr_i) begin
						rx_nc_ff  <= 8'd0;
						rx_cnt_ff <= rx_cnt_ff + 8'd1;
						if (rx_cnt_ff + 8'd1 == rx_need_ff)
							rx_st_ff <= R_CHECK;
					end else begin
						rx_nc_ff <= rx_nc_ff + 8'd1;
						if (!rx_len_ff && ctrl_ff[CTRL_NCORR] && rx_mode_ff != MODE_FSK &&
						    rx_nc_ff + 8'd1 >= ncorr_ff)
							rx_st_ff <= R_CHECK;
					end
				end
				R_CHECK: begin
					rx_st_ff <= R_HUNT;
					if (rx_ok && ctrl_ff[CTRL_AUTOACK])
						ack_req_ff <= 1'b1;
				end
				default: rx_st_ff <= R_HUNT;
			endcase
		end
	end

	// two-byte delay so the trailing crc never reaches the buffer
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			p0_ff   <= 8'h00;
			p1_ff   <= 8'h00;
			pcnt_ff <= 2'd0;
		end else if (rx_st_ff == R_HUNT) begin
			pcnt_ff <= 2'd0;
		end else if (rx_body) begin
			p0_ff <= air_rx_byte_i;
			p1_ff <= p0_ff;
			if (pcnt_ff != 2'd2)
				pcnt_ff <= pcnt_ff + 2'd1;
		end
	end

	rpf_crc16 u_rx_crc_seed (
		.clk_i  (clk_i),
		.rst_ni (rst_n),
		.load_i (rx_st_ff == R_HUNT),
		.seed_i (seed_ff),
		.step_i (rx_emit),
		.byte_i (rx_emit_b),
		.crc_o  (rx_crc_s)
	);

	rpf_crc16 u_rx_crc_zero (
		.clk_i  (clk_i),
		.rst_ni (rst_n),
		.load_i (rx_st_ff == R_HUNT),
		.seed_i (16'h0000),
		.step_i (rx_emit),
		.byte_i (rx_emit_b),
		.crc_o  (rx_crc_z)
	);

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n);

	logic [1:0] mk_seen_ff;
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n)
			mk_seen_ff <= 2'd0;
		else if (tx_start)
			mk_seen_ff <= 2'd0;
		else if (air_tx_stb_o && air_tx_marker_o && mk_seen_ff != 2'd3)
			mk_seen_ff <= mk_seen_ff + 2'd1;
	end

	sequence s_last_byte;
		rx_body && rx_len_ff && (rx_cnt_ff + 8'd1 == rx_need_ff);
	endsequence
	sequence s_bad_check;
		(rx_st_ff == R_CHECK) && !rx_ok;
	endsequence

	a_two_marker_syms: assert property (air_tx_stb_o && !air_tx_marker_o && tx_mark_ff |-> mk_seen_ff == 2'd2)
		else $error("data before two marker symbols");
	a_sdr_no_marker: assert property (mode == MODE_SDR |-> !mark_on && !len_on)
		else $error("marker enabled in single rate");
	a_len_needs_mark: assert property (len_on |-> mark_on)
		else $error("length field without marker");
	a_fsk_no_ncorr: assert property (mode == MODE_FSK |-> !ncorr_on)
		else $error("non-correlation end in fsk");
	a_end_on_length: assert property (s_last_byte |=> rx_st_ff == R_CHECK ##1 rx_st_ff == R_HUNT)
		else $error("end not declared after length");
	a_bad_crc_noack: assert property (s_bad_check |=> crcerr_ff && !ack_req_ff)
		else $error("bad crc acknowledged or not flagged");
	a_chan_in_range: assert property (chan_ff <= 7'(NUM_CHANNELS - 1))
		else $error("channel out of range");
	a_ack_keeps_buf: assert property (tx_ack_ff && tx_st_ff != T_IDLE |-> $stable(tx_rp_ff) && !tx_pop)
		else $error("acknowledge touched transmit buffer");
	a_payload_bound: assert property (tx_cnt_ff <= 6'(MAX_PAYLOAD) && rx_need_ff <= 8'(MAX_PAYLOAD + 2))
		else $error("payload beyond limit");
endmodule : rpf_top

// file: tb/rpf_peer.sv
// Purpose: peer framer model on the air link
// Assumes: one symbol per strobe, fsk rate
// Notes:   records each symbol the framer sends
`timescale 1ns/1ps
module rpf_peer
	import rpf_pkg::*;
(
	input  wire logic       clk_i,   // clock
	input  wire logic       stb_i,   // framer symbol strobe
	input  wire logic       mark_i,  // framer marker flag
	input  wire logic [7:0] byte_i,  // framer symbol byte
	output logic            stb_o,   // symbol to framer
	output logic            corr_o,  // symbol correlated
	output logic            mark_o,  // marker correlated
	output logic      [7:0] byte_o,  // symbol byte
	output logic      [1:0] rate_o   // frame rate
);
	logic [8:0] got[$];
	initial begin
		stb_o = 1'b0;
		corr_o = 1'b0;
		mark_o = 1'b0;
		byte_o = 8'hFF;
		rate_o = MODE_FSK;
	end
	always @(posedge clk_i) begin
		if (stb_i) begin
			got.push_back({mark_i, byte_i});
		end
	end
	task automatic sym(input logic mk, input logic [7:0] b);
		@(posedge clk_i);
		stb_o <= 1'b1;
		corr_o <= 1'b1;
		mark_o <= mk;
		byte_o <= b;
		@(posedge clk_i);
		stb_o <= 1'b0;
		corr_o <= 1'b0;
		mark_o <= 1'b0;
		byte_o <= ~b; // no stale value off strobe
		repeat (3) @(posedge clk_i);
	endtask : sym
	task automatic miss();
		@(posedge clk_i);
		stb_o <= 1'b1;
		@(posedge clk_i);
		stb_o <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask : miss
	task automatic frame(input logic [7:0] d0, input logic [7:0] d1, input logic [15:0] c);
		sym(1'b1, 8'h00);
		sym(1'b1, 8'h00);
		sym(1'b0, 8'h02);
		sym(1'b0, d0);
		sym(1'b0, d1);
		sym(1'b0, c[7:0]);
		sym(1'b0, c[15:8]);
	endtask : frame
endmodule : rpf_peer

// file: tb/test_radio_packet_framer.sv
// Purpose: self-checking bench of the framer
// Assumes: fsk link except the last, double rate case; peer model on the air side
// Notes:   register rows first, then link cases
`timescale 1ns/1ps
module test_radio_packet_framer;
	import rpf_pkg::*;
	logic clk_i, nrst_i, wr_i, rd_i, tx_on, tx_stb, tx_mk, rx_stb, rx_corr, rx_mk, spr, m64, b64;
	logic [7:0] addr_i, tx_b, rx_b;
	logic [15:0] wdata_i, rdata_o, v, c;
	logic [6:0] chan;
	logic [1:0] mode, rate;
	int bad_count = 0;
	int compares = 0;
	localparam logic [39:0] ROWS [7] = '{{REG_CTRL, 16'h0015, 16'h0015}, {REG_SEED, 16'h1234, 16'h1234},
		{REG_CODE, 16'h0003, 16'h0003}, {REG_NCORR, 16'h0000, 16'h0001}, {REG_CHAN, 16'h0064, 16'h0061},
		{REG_TXLEN, 16'h0032, 16'h0028}, {8'h30, 16'hFFFF, 16'h0000}};
	rpf_top #(.SDR_CYC(8)) dut (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.air_tx_on_o(tx_on), .air_tx_stb_o(tx_stb), .air_tx_marker_o(tx_mk), .air_tx_byte_o(tx_b),
		.air_rx_stb_i(rx_stb), .air_rx_corr_i(rx_corr), .air_rx_marker_i(rx_mk), .air_rx_byte_i(rx_b),
		.air_rx_rate_i(rate), .channel_o(chan), .mode_o(mode), .spread_en_o(spr), .marker_64_o(m64),
		.body_64_o(b64));
	rpf_peer peer (.clk_i, .stb_i(tx_stb), .mark_i(tx_mk), .byte_i(tx_b), .stb_o(rx_stb),
		.corr_o(rx_corr), .mark_o(rx_mk), .byte_o(rx_b), .rate_o(rate));
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic conclude();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : conclude
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask : rd
	task automatic wait_syms(input int n);
		for (int i = 0; i < 3000 && peer.got.size() < n; i++) @(posedge clk_i);
		if (peer.got.size() < n) begin
			chk(16'(peer.got.size()), 16'(n));
			conclude();
		end
	endtask : wait_syms
	task automatic frame_chk(input logic [7:0] body[$]);
		chk(16'({peer.got[0][8], peer.got[1][8]}), 16'h0003);
		foreach (body[i]) chk(16'(peer.got[i+2]), {8'h00, body[i]});
		peer.got.delete();
	endtask : frame_chk
	function automatic logic [15:0] crc(input logic [15:0] s, input logic [7:0] b);
		logic [15:0] r;
		r = s ^ {8'h00, b};
		for (int k = 0; k < 8; k++) r = r[0] ? (r >> 1) ^ CRC_POLY_REFL : r >> 1;
		return r;
	endfunction : crc
	initial begin
		nrst_i = 1'b0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		addr_i = 8'h00;
		wdata_i = 16'h0000;
		repeat (8) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rd(REG_CTRL, v);
		chk(v, 16'(CTRL_RESET));
		rd(REG_NCORR, v);
		chk(v, 16'(NCORR_RESET));
		foreach (ROWS[i]) begin
			wr(ROWS[i][39:32], ROWS[i][31:16]);
			rd(ROWS[i][39:32], v);
			chk(v, ROWS[i][15:0]);
		end
		chk(16'(chan), 16'h0061);
		chk(16'({mode, spr, m64, b64}), 16'h0003);
		wr(REG_TXLEN, 16'h0001);
		for (int z = 0; z < 2; z++) begin
			wr(REG_CTRL, z ? 16'h001D : 16'h0015);
			wr(REG_TXDATA, 16'h00A5);
			wr(REG_CMD, 16'h0001);
			wait_syms(6);
			c = crc(z ? 16'h0000 : 16'h1234, 8'hA5);
			frame_chk('{8'h01, 8'hA5, c[7:0], c[15:8]});
		end
		wr(REG_CTRL, 16'h0015);
		c = crc(crc(16'h0000, 8'h3C), 8'hC3);
		peer.frame(8'h3C, 8'hC3, c);
		wait_syms(5);
		frame_chk('{8'h00, 8'h34, 8'h12});
		rd(REG_STAT, v);
		chk(16'(v[3:1]), 16'h0005);
		rd(REG_RXDATA, v);
		chk(v, 16'h003C);
		rd(REG_RXDATA, v);
		chk(v, 16'h00C3);
		wr(REG_STAT, 16'h001E);
		peer.frame(8'h3C, 8'hC3, c ^ 16'h0001);
		rd(REG_STAT, v);
		chk(16'(v[3:1]), 16'h0003);
		chk(16'({tx_on, 8'(peer.got.size())}), 16'h0000);
		wr(REG_STAT, 16'h001E);
		// double rate, unframed, crc off, end on non-correlation
		wr(REG_CTRL, 16'h0220);
		peer.sym(1'b0, 8'h11);
		peer.sym(1'b0, 8'h22);
		peer.sym(1'b0, 8'h5A);
		peer.miss();
		rd(REG_STAT, v);
		chk(16'({mode, v[2:1], spr}), 16'h0013);
		repeat (3) rd(REG_RXDATA, v);
		chk(v, 16'h005A);
		conclude();
	end
endmodule : test_radio_packet_framer
